/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int BUZZ_C = 40;
	localparam int PING_C = 30;
	localparam int BOOT_C = 20;
	logic clock = 1'b0;
	logic arst_n, supply, comp, present, metal;
	logic [3:0] scheme;
	logic [3:0] loss_sel;
	logic overtemp, die_hot, cooled, ept, report;
	logic [6:0] pct;
	logic rx_present, ping_valid, power_enable, ping_request, green_lamp, red_lamp;
	logic dc_buzzer, tone_buzzer, firmware_load, sleep_command, metal_loss_detect;
	logic [15:0] rx_power, tx_power;
	int pings = 0;
	int sleeps = 0;
	int fws = 0;
	int cyc = 0;
	int bad_count = 0;
	int n_tests = 0;
	logic [3:0] sch [5] = '{4'h9, 4'ha, 4'h1, 4'hc, 4'h0};
	logic [1:0] lmp [5] = '{2'b11, 2'b11, 2'b00, 2'b00, 2'b00};
	wtip_supervisor #(.WARN_CYCLES(50), .HALT_CYCLES(100), .TMO_CYCLES(80),
		.BUZZ_CYCLES(BUZZ_C), .PING_CYCLES(PING_C), .BOOT_CYCLES(BOOT_C), .LOAD_CYCLES(20),
		.SLEEP_EVERY(8), .SLOW_HALF(8), .FAST_HALF(3)) wtip_supervisor_inst (
		.clock(clock), .arst_n(arst_n), .digital_supply_sense(supply),
		.lamp_scheme_select(scheme), .loss_threshold_select(loss_sel),
		.companion_strap(comp), .coil_overtemp(overtemp), .die_hot(die_hot),
		.die_cooled(cooled), .rx_present(rx_present), .ping_valid(ping_valid),
		.ept_charge_done(ept), .charge_report(report), .charge_percent(pct),
		.rx_power(rx_power), .tx_power(tx_power), .power_enable(power_enable),
		.ping_request(ping_request), .green_lamp(green_lamp), .red_lamp(red_lamp),
		.dc_buzzer(dc_buzzer), .tone_buzzer(tone_buzzer), .firmware_load(firmware_load),
		.sleep_command(sleep_command), .metal_loss_detect(metal_loss_detect));
	wtip_rx_model wtip_rx_model_inst (.clock(clock), .arst_n(arst_n), .present(present),
		.metal(metal), .rx_present(rx_present), .ping_valid(ping_valid),
		.rx_power(rx_power), .tx_power(tx_power));
	always #5 clock = ~clock;
	// Pulse counters and the hang guard
	always @(posedge clock) begin
		pings <= pings + (ping_request === 1'b1);
		sleeps <= sleeps + (sleep_command === 1'b1);
		fws <= fws + (firmware_load === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			bad_count++;
			test_done;
		end
	end
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Ends just after the edge, where outputs have settled
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wait_pe(input logic v, input int lim, output int c);
		c = 0;
		while (power_enable !== v && c < lim) begin
			tick(1);
			c++;
		end
	endtask
	task automatic wait_ping(output int c);
		int p;
		p = pings;
		c = 0;
		while (pings == p && c < 500) begin
			tick(1);
			c++;
		end
	endtask
	// Counts lamp changes, red when sel is set
	task automatic flips(input bit sel, input int n, output int t);
		logic v;
		logic w;
		t = 0;
		v = sel ? red_lamp : green_lamp;
		repeat (n) begin
			tick(1);
			w = sel ? red_lamp : green_lamp;
			t += (w !== v);
			v = w;
		end
	endtask
	task automatic send_report(input logic [6:0] p);
		@(posedge clock);
		report <= 1'b1;
		pct <= p;
		@(posedge clock);
		report <= 1'b0;
		// Let the registered lamps follow before anyone looks
		tick(2);
	endtask
	// Supply stays low a while after reset to hold off start-up
	task automatic restart(input logic [3:0] s, input logic c);
		arst_n <= 1'b0;
		supply <= 1'b0;
		scheme <= s;
		comp <= c;
		present <= 1'b0;
		metal <= 1'b0;
		loss_sel <= 4'h4;
		overtemp <= 1'b0;
		die_hot <= 1'b0;
		cooled <= 1'b1;
		ept <= 1'b0;
		report <= 1'b0;
		pct <= 7'h00;
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		repeat (8) @(posedge clock);
		supply <= 1'b1;
	endtask
	initial begin
		int c;
		int t;
		restart(4'h9, 1'b0);
		tick(BOOT_C - 2);
		check(pings, 0);
		wait_ping(c);
		wait_ping(c);
		check(c, PING_C);
		$display("test boot done");
		present <= 1'b1;
		wait_pe(1'b1, 200, c);
		check(dc_buzzer, 1'b1);
		flips(1'b0, BUZZ_C + 2, t);
		check(t >= 4, 1'b1);
		check({dc_buzzer, tone_buzzer}, 2'b00);
		send_report(7'h64);
		flips(1'b0, 20, t);
		check({t[3:0], green_lamp, power_enable}, 6'h03);
		send_report(7'h32);
		flips(1'b0, 20, t);
		check(t, 0);
		tick(50);
		flips(1'b0, 30, t);
		check(t >= 2, 1'b1);
		$display("test charge done");
		metal <= 1'b1;
		tick(10);
		check(metal_loss_detect, 1'b1);
		flips(1'b1, 18, t);
		check(t >= 4, 1'b1);
		metal <= 1'b0;
		tick(5);
		check({metal_loss_detect, power_enable}, 2'b01);
		metal <= 1'b1;
		wait_pe(1'b0, 200, c);
		check(c > 45 && c < 60, 1'b1);
		wait_pe(1'b1, 300, c);
		check(c > 95 && c < 140, 1'b1);
		metal <= 1'b0;
		$display("test loss done");
		tick(BUZZ_C + 2);
		ept <= 1'b1;
		tick(1);
		ept <= 1'b0;
		tick(3);
		check({power_enable, green_lamp, red_lamp}, 3'b010);
		wait_pe(1'b1, 300, c);
		check(c > 90 && c < 300, 1'b1);
		tick(BUZZ_C + 2);
		overtemp <= 1'b1;
		tick(1);
		overtemp <= 1'b0;
		tick(3);
		check({power_enable, red_lamp}, 2'b01);
		present <= 1'b0;
		tick(5);
		present <= 1'b1;
		wait_pe(1'b1, 300, c);
		check(c < 90, 1'b1);
		die_hot <= 1'b1;
		cooled <= 1'b0;
		tick(80);
		check(power_enable, 1'b0);
		die_hot <= 1'b0;
		cooled <= 1'b1;
		wait_pe(1'b1, 200, c);
		check(c < 200, 1'b1);
		loss_sel <= 4'hd;
		metal <= 1'b1;
		tick(20);
		check({metal_loss_detect, power_enable}, 2'b01);
		$display("test faults done");
		for (int i = 0; i < 5; i++) begin
			restart(sch[i], 1'b0);
			tick(BOOT_C + 20);
			check({green_lamp, red_lamp}, lmp[i]);
		end
		restart(4'ha, 1'b0);
		present <= 1'b1;
		wait_pe(1'b1, 200, c);
		send_report(7'h64);
		check(green_lamp, 1'b1);
		send_report(7'h50);
		flips(1'b0, 20, t);
		check(t >= 2, 1'b1);
		$display("test schemes done");
		restart(4'h9, 1'b1);
		tick(BOOT_C + 40);
		check(fws > 0, 1'b1);
		tick(8 * PING_C + 60);
		check(sleeps > 0, 1'b1);
		// External reset with the supply already good must still start up
		@(posedge clock);
		arst_n <= 1'b0;
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		c = pings;
		tick(BOOT_C + 2 * PING_C + 10);
		check(pings > c, 1'b1);
		$display("test companion done");
		test_done;
	end
endmodule
`default_nettype wire

/* File: wtip_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module wtip_checker #(
	parameter int unsigned     BUZZ_CYCLES = 40,
	parameter longint unsigned WARN_CYCLES = 50
) (
	// Clock and reset
	input wire logic       clock,
	input wire logic       arst_n,
	// Inputs seen
	input wire logic       digital_supply_sense,
	input wire logic [3:0] lamp_scheme_select,
	input wire logic       companion_strap,
	input wire logic       die_hot,
	input wire logic       ept_charge_done,
	// Outputs seen
	input wire logic       power_enable,
	input wire logic       ping_request,
	input wire logic       green_lamp,
	input wire logic       red_lamp,
	input wire logic       dc_buzzer,
	input wire logic       tone_buzzer,
	input wire logic       firmware_load,
	input wire logic       sleep_command,
	input wire logic       metal_loss_detect
);
	longint unsigned dc_cnt;
	longint unsigned ml_cnt;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Run lengths of the buzzer burst and of the loss warning
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			dc_cnt <= 0;
		else
			dc_cnt <= dc_buzzer ? dc_cnt + 1 : 0;
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			ml_cnt <= 0;
		else
			ml_cnt <= metal_loss_detect ? ml_cnt + 1 : 0;
	end
	sequence s_burst;
		dc_buzzer [*8];
	endsequence
	sequence s_hold;
		ept_charge_done && power_enable && lamp_scheme_select inside {[4'h1:4'ha]};
	endsequence
	property p_buzz_start;
		$rose(power_enable) |-> dc_buzzer && tone_buzzer ##1 s_burst;
	endproperty
	a_buzz_start: assert property (p_buzz_start) else $error("buzzer start");
	property p_buzz_len;
		$fell(dc_buzzer) |-> dc_cnt == BUZZ_CYCLES;
	endproperty
	a_buzz_len: assert property (p_buzz_len) else $error("buzzer length");
	property p_tone_idle;
		!dc_buzzer |-> !tone_buzzer;
	endproperty
	a_tone_idle: assert property (p_tone_idle) else $error("tone idle");
	property p_ping_pulse;
		ping_request |=> !ping_request;
	endproperty
	a_ping_pulse: assert property (p_ping_pulse) else $error("ping pulse");
	property p_sleep;
		sleep_command |-> !power_enable ##1 !sleep_command;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep pulse");
	property p_fw;
		firmware_load |-> companion_strap && !power_enable;
	endproperty
	a_fw: assert property (p_fw) else $error("firmware load");
	property p_supply;
		!digital_supply_sense |-> ##[1:2] !power_enable;
	endproperty
	a_supply: assert property (p_supply) else $error("supply low");
	property p_ept;
		s_hold |-> ##[1:2] (!power_enable && green_lamp);
	endproperty
	a_ept: assert property (p_ept) else $error("charge done");
	property p_hot;
		die_hot && !power_enable |=> !power_enable;
	endproperty
	a_hot: assert property (p_hot) else $error("die hot");
	property p_loss_len;
		ml_cnt <= WARN_CYCLES + 1;
	endproperty
	a_loss_len: assert property (p_loss_len) else $error("warning length");
	property p_reserved;
		(lamp_scheme_select > 4'ha) [*3] |-> !green_lamp && !red_lamp;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved lamps");
endmodule
bind wtip_supervisor wtip_checker #(.BUZZ_CYCLES(BUZZ_CYCLES), .WARN_CYCLES(WARN_CYCLES))
	wtip_checker_inst (.clock(clock), .arst_n(arst_n),
	.digital_supply_sense(digital_supply_sense), .lamp_scheme_select(lamp_scheme_select),
	.companion_strap(companion_strap), .die_hot(die_hot), .ept_charge_done(ept_charge_done),
	.power_enable(power_enable), .ping_request(ping_request), .green_lamp(green_lamp),
	.red_lamp(red_lamp), .dc_buzzer(dc_buzzer), .tone_buzzer(tone_buzzer),
	.firmware_load(firmware_load), .sleep_command(sleep_command),
	.metal_loss_detect(metal_loss_detect));
`default_nettype wire

/* File: wtip_pkg.sv */
package wtip_pkg;
	localparam int unsigned CLOCK_HZ        = 100_000_000;
	localparam int unsigned BUZZ_MS         = 400;
	localparam int unsigned PING_MS         = 400;
	localparam int unsigned TONE_HZ         = 4000;
	localparam int unsigned WARN_S          = 20;
	localparam int unsigned HALT_S          = 300;
	localparam int unsigned TIMEOUT_S       = 360;
	localparam int unsigned BUZZ_CYCLES     = CLOCK_HZ / 1000 * BUZZ_MS;
	localparam int unsigned PING_CYCLES     = CLOCK_HZ / 1000 * PING_MS;
	localparam int unsigned TONE_HALF       = CLOCK_HZ / TONE_HZ / 2;
	localparam longint unsigned WARN_CYCLES = longint'(CLOCK_HZ) * WARN_S;
	localparam longint unsigned HALT_CYCLES = longint'(CLOCK_HZ) * HALT_S;
	localparam longint unsigned TMO_CYCLES  = longint'(CLOCK_HZ) * TIMEOUT_S;
	localparam logic [3:0] SCHEME_GEN_ALL   = 4'h1;
	localparam logic [3:0] SCHEME_GEN       = 4'h2;
	localparam logic [3:0] SCHEME_GEN_100   = 4'h3;
	localparam logic [3:0] SCHEME_GEN_90    = 4'h4;
	localparam logic [3:0] SCHEME_GEN_6M    = 4'h5;
	localparam logic [3:0] SCHEME_SUG       = 4'h6;
	localparam logic [3:0] SCHEME_SUG_100   = 4'h7;
	localparam logic [3:0] SCHEME_SUG_90    = 4'h8;
	localparam logic [3:0] SCHEME_SUG_6M    = 4'h9;
	localparam logic [3:0] SCHEME_SUG_ALL   = 4'ha;
	localparam logic [3:0] LOSS_BIN_OFF     = 4'hd;
	localparam logic [6:0] CHARGE_FULL      = 7'h64;
	localparam logic [6:0] CHARGE_LOW       = 7'h5a;
	typedef enum logic [6:0] {
		WTIP_BOOT    = 7'h01,
		WTIP_LOAD    = 7'h02,
		WTIP_STANDBY = 7'h04,
		WTIP_XFER    = 7'h08,
		WTIP_DONE    = 7'h10,
		WTIP_HALT    = 7'h20,
		WTIP_SUSPEND = 7'h40
	} wtip_state_type;
endpackage

/* File: wtip_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wtip_rx_model (
	// Clock and reset
	input  wire logic  clock,
	input  wire logic  arst_n,
	// Commands from the bench
	input  wire logic  present,
	input  wire logic  metal,
	// Toward the transmitter
	output logic       rx_present,
	output logic       ping_valid,
	output logic [15:0] rx_power,
	output logic [15:0] tx_power
);
	// An absent receiver reports nothing, so its words churn
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rx_present <= 1'b0;
			ping_valid <= 1'b0;
			rx_power <= 16'h0000;
			tx_power <= 16'h0000;
		end else begin
			rx_present <= present;
			ping_valid <= present;
			rx_power <= present ? 16'h1000 : ~rx_power;
			tx_power <= present ? (metal ? 16'h4000 : 16'h1100) : ~tx_power;
		end
	end
endmodule
`default_nettype wire

/* File: wtip_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
module wtip_supervisor #(
	parameter longint unsigned WARN_CYCLES = wtip_pkg::WARN_CYCLES,
	parameter longint unsigned HALT_CYCLES = wtip_pkg::HALT_CYCLES,
	parameter longint unsigned TMO_CYCLES  = wtip_pkg::TMO_CYCLES,
	parameter int unsigned     BUZZ_CYCLES = wtip_pkg::BUZZ_CYCLES,
	parameter int unsigned     PING_CYCLES = wtip_pkg::PING_CYCLES,
	parameter int unsigned     BOOT_CYCLES = 1000,
	parameter int unsigned     LOAD_CYCLES = 1000,
	parameter int unsigned     SLEEP_EVERY = 8,
	parameter int unsigned     SLOW_HALF   = 50_000_000,
	parameter int unsigned     FAST_HALF   = 12_500_000
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       arst_n,
	// Supply, straps and thermal
	input  wire logic       digital_supply_sense,
	input  wire logic [3:0] lamp_scheme_select,
	input  wire logic [3:0] loss_threshold_select,
	input  wire logic       companion_strap,
	input  wire logic       coil_overtemp,
	input  wire logic       die_hot,
	input  wire logic       die_cooled,
	// Receiver and power path
	input  wire logic       rx_present,
	input  wire logic       ping_valid,
	input  wire logic       ept_charge_done,
	input  wire logic       charge_report,
	input  wire logic [6:0] charge_percent,
	input  wire logic [15:0] rx_power,
	input  wire logic [15:0] tx_power,
	// Outputs
	output logic            power_enable,
	output logic            ping_request,
	output logic            green_lamp,
	output logic            red_lamp,
	output logic            dc_buzzer,
	output logic            tone_buzzer,
	output logic            firmware_load,
	output logic            sleep_command,
	output logic            metal_loss_detect
);
	// Elaboration checks on the counts the logic can serve
	if (FAST_HALF == 0 || FAST_HALF >= SLOW_HALF)
		$error("fast blink must be shorter than slow blink");
	if (WARN_CYCLES == 0 || HALT_CYCLES == 0 || TMO_CYCLES == 0 || BUZZ_CYCLES == 0)
		$error("timer counts must be nonzero");
	if (SLEEP_EVERY == 0 || SLEEP_EVERY > 256)
		$error("sleep spacing must fit the ping counter");

	wtip_pkg::wtip_state_type state;
	wtip_pkg::wtip_state_type next_state;
	wtip_tick_if tick ();
	wtip_timer u_timer (
		.clock  (clock),
		.arst_n (arst_n),
		.tick   (tick)
	);

	logic        die_stop;
	logic        opt_full;
	logic        opt_ninety;
	logic        opt_timeout;
	logic        suggested;
	logic        reserved;
	logic        full_shown;
	logic        warning;
	logic [35:0] warn_count;
	logic [35:0] tmo_count;
	logic [31:0] phase_count;
	logic [31:0] slow_count;
	logic [31:0] fast_count;
	logic        slow_blink;
	logic        fast_blink;
	logic [31:0] buzz_count;
	logic [15:0] tone_count;
	logic [7:0]  ping_count;
	logic        loss_high;
	logic [15:0] loss;
	logic [15:0] loss_limit;
	logic        ping_tick;
	logic        entering_xfer;
	logic        boot_armed;

	// Scheme decode; reserved codes fall to a dark, option-free setting
	always_comb begin
		suggested   = lamp_scheme_select >= wtip_pkg::SCHEME_SUG;
		reserved    = lamp_scheme_select > wtip_pkg::SCHEME_SUG_ALL
		              || lamp_scheme_select == 4'h0;
		opt_full    = 1'b0;
		opt_ninety  = 1'b0;
		opt_timeout = 1'b0;
		if (lamp_scheme_select == wtip_pkg::SCHEME_GEN_ALL) begin
			opt_full    = 1'b1;
			opt_ninety  = 1'b1;
			opt_timeout = 1'b1;
		end else if (lamp_scheme_select == wtip_pkg::SCHEME_GEN_100
		             || lamp_scheme_select == wtip_pkg::SCHEME_SUG_100) begin
			opt_full = 1'b1;
		end else if (lamp_scheme_select == wtip_pkg::SCHEME_GEN_90
		             || lamp_scheme_select == wtip_pkg::SCHEME_SUG_90) begin
			opt_full   = 1'b1;
			opt_ninety = 1'b1;
		end else if (lamp_scheme_select == wtip_pkg::SCHEME_GEN_6M
		             || lamp_scheme_select == wtip_pkg::SCHEME_SUG_6M) begin
			opt_full    = 1'b1;
			opt_timeout = 1'b1;
		end else if (lamp_scheme_select == wtip_pkg::SCHEME_SUG_ALL) begin
			opt_full    = 1'b1;
			opt_ninety  = 1'b1;
			opt_timeout = 1'b1;
		end
	end

	// Parasitic loss estimate against a strap-chosen bin
	always_comb begin
		loss       = (tx_power > rx_power) ? tx_power - rx_power : 16'h0;
		loss_limit = {2'h0, loss_threshold_select, 10'h0};
		loss_high  = loss_threshold_select < wtip_pkg::LOSS_BIN_OFF
		             && loss > loss_limit;
	end

	// Die sensor latch with hysteresis between trip and cool flags
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			die_stop <= 1'b0;
		end else if (die_hot) begin
			die_stop <= 1'b1;
		end else if (die_cooled) begin
			die_stop <= 1'b0;
		end
	end

	// Sequencer; arst_n doubles as the external reset pin
	always_comb begin
		next_state = state;
		case (state)
		wtip_pkg::WTIP_BOOT: begin
			if (tick.expired)
				next_state = companion_strap ? wtip_pkg::WTIP_LOAD : wtip_pkg::WTIP_STANDBY;
		end
		wtip_pkg::WTIP_LOAD: begin
			if (tick.expired)
				next_state = wtip_pkg::WTIP_STANDBY;
		end
		wtip_pkg::WTIP_STANDBY: begin
			if (ping_tick && ping_valid && !die_stop && !die_hot)
				next_state = wtip_pkg::WTIP_XFER;
		end
		wtip_pkg::WTIP_XFER: begin
			if (die_stop || !rx_present)
				next_state = wtip_pkg::WTIP_STANDBY;
			else if (coil_overtemp)
				next_state = wtip_pkg::WTIP_SUSPEND;
			else if (ept_charge_done)
				next_state = wtip_pkg::WTIP_DONE;
			else if (warning && warn_count == 36'h0)
				next_state = wtip_pkg::WTIP_HALT;
		end
		wtip_pkg::WTIP_DONE, wtip_pkg::WTIP_HALT: begin
			if (tick.expired)
				next_state = wtip_pkg::WTIP_STANDBY;
		end
		wtip_pkg::WTIP_SUSPEND: begin
			if (tick.expired || !rx_present)
				next_state = wtip_pkg::WTIP_STANDBY;
		end
		default: next_state = wtip_pkg::WTIP_BOOT;
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			state <= wtip_pkg::WTIP_BOOT;
		else if (!digital_supply_sense)
			state <= wtip_pkg::WTIP_BOOT;
		else
			state <= next_state;
	end

	// Boot countdown arms on the first cycle of each visit, so a reset released
	// with the supply already good still starts up
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			boot_armed <= 1'b0;
		else
			boot_armed <= state == wtip_pkg::WTIP_BOOT;
	end

	// Timer loads on entering each timed state
	always_comb begin
		tick.load  = 1'b0;
		tick.count = 36'h0;
		if (state != next_state) begin
			tick.load = 1'b1;
			case (next_state)
			wtip_pkg::WTIP_LOAD:    tick.count = 36'(LOAD_CYCLES);
			wtip_pkg::WTIP_DONE:    tick.count = 36'(HALT_CYCLES);
			wtip_pkg::WTIP_HALT:    tick.count = 36'(HALT_CYCLES);
			wtip_pkg::WTIP_SUSPEND: tick.count = 36'(HALT_CYCLES);
			default:                tick.load  = 1'b0;
			endcase
		end else if (state == wtip_pkg::WTIP_BOOT
		             && (!digital_supply_sense || !boot_armed)) begin
			tick.load  = 1'b1;
			tick.count = 36'(BOOT_CYCLES);
		end
	end

	// Warning window; a clear loss ends it immediately
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			warning    <= 1'b0;
			warn_count <= 36'h0;
		end else if (state != wtip_pkg::WTIP_XFER || !loss_high) begin
			warning    <= 1'b0;
			warn_count <= 36'h0;
		end else if (!warning) begin
			warning    <= 1'b1;
			warn_count <= 36'(WARN_CYCLES - 1);
		end else if (warn_count != 36'h0) begin
			warn_count <= warn_count - 36'h1;
		end
	end

	// Full-charge lamp override; power path is never touched here
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			full_shown <= 1'b0;
			tmo_count  <= 36'h0;
		end else if (state != wtip_pkg::WTIP_XFER) begin
			full_shown <= 1'b0;
		end else if (charge_report && opt_full && charge_percent == wtip_pkg::CHARGE_FULL) begin
			full_shown <= 1'b1;
			tmo_count  <= 36'(TMO_CYCLES);
		end else if (full_shown && opt_ninety && charge_report
		             && charge_percent < wtip_pkg::CHARGE_LOW) begin
			full_shown <= 1'b0;
		end else if (full_shown && opt_timeout) begin
			if (tmo_count == 36'h0)
				full_shown <= 1'b0;
			else
				tmo_count <= tmo_count - 36'h1;
		end
	end

	// Blink generators, free running
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			slow_count <= 32'h0;
			fast_count <= 32'h0;
			slow_blink <= 1'b0;
			fast_blink <= 1'b0;
		end else begin
			slow_count <= (slow_count >= SLOW_HALF - 1) ? 32'h0 : slow_count + 32'h1;
			fast_count <= (fast_count >= FAST_HALF - 1) ? 32'h0 : fast_count + 32'h1;
			if (slow_count >= SLOW_HALF - 1)
				slow_blink <= !slow_blink;
			if (fast_count >= FAST_HALF - 1)
				fast_blink <= !fast_blink;
		end
	end

	// Lamp patterns; registered so the pins never glitch
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			green_lamp <= 1'b0;
			red_lamp   <= 1'b0;
		end else if (reserved) begin
			green_lamp <= 1'b0;
			red_lamp   <= 1'b0;
		end else if (state == wtip_pkg::WTIP_STANDBY) begin
			green_lamp <= suggested;
			red_lamp   <= suggested;
		end else if (state == wtip_pkg::WTIP_XFER && warning) begin
			green_lamp <= 1'b0;
			red_lamp   <= fast_blink;
		end else if (state == wtip_pkg::WTIP_DONE
		             || (state == wtip_pkg::WTIP_XFER && full_shown)) begin
			green_lamp <= 1'b1;
			red_lamp   <= 1'b0;
		end else if (state == wtip_pkg::WTIP_XFER) begin
			green_lamp <= slow_blink;
			red_lamp   <= 1'b0;
		end else if (state == wtip_pkg::WTIP_HALT || state == wtip_pkg::WTIP_SUSPEND) begin
			green_lamp <= 1'b0;
			red_lamp   <= lamp_scheme_select != wtip_pkg::SCHEME_GEN;
		end else begin
			green_lamp <= 1'b0;
			red_lamp   <= 1'b0;
		end
	end

	assign entering_xfer = state != wtip_pkg::WTIP_XFER && next_state == wtip_pkg::WTIP_XFER;

	// Buzzers: one 0.4 s burst per transfer start
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			buzz_count  <= 32'h0;
			tone_count  <= 16'h0;
			dc_buzzer   <= 1'b0;
			tone_buzzer <= 1'b0;
		end else if (entering_xfer) begin
			buzz_count  <= 32'(BUZZ_CYCLES - 1);
			tone_count  <= 16'h0;
			dc_buzzer   <= 1'b1;
			tone_buzzer <= 1'b1;
		end else if (buzz_count != 32'h0) begin
			buzz_count <= buzz_count - 32'h1;
			if (tone_count >= 16'(wtip_pkg::TONE_HALF - 1)) begin
				tone_count  <= 16'h0;
				tone_buzzer <= !tone_buzzer;
			end else begin
				tone_count <= tone_count + 16'h1;
			end
		end else begin
			dc_buzzer   <= 1'b0;
			tone_buzzer <= 1'b0;
		end
	end

	// Standby ping cadence and companion sleep requests
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			phase_count <= 32'h0;
			ping_count  <= 8'h0;
		end else if (state != wtip_pkg::WTIP_STANDBY || ping_tick) begin
			phase_count <= 32'h0;
			if (ping_tick)
				ping_count <= (ping_count >= 8'(SLEEP_EVERY - 1)) ? 8'h0 : ping_count + 8'h1;
		end else begin
			phase_count <= phase_count + 32'h1;
		end
	end

	assign ping_tick = state == wtip_pkg::WTIP_STANDBY
	                   && phase_count >= PING_CYCLES - 1;

	// Registered status outputs
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			power_enable      <= 1'b0;
			ping_request      <= 1'b0;
			firmware_load     <= 1'b0;
			sleep_command     <= 1'b0;
			metal_loss_detect <= 1'b0;
		end else begin
			power_enable      <= digital_supply_sense
			                     && next_state == wtip_pkg::WTIP_XFER;
			ping_request      <= ping_tick;
			firmware_load     <= next_state == wtip_pkg::WTIP_LOAD;
			sleep_command     <= ping_tick && companion_strap
			                     && next_state == wtip_pkg::WTIP_STANDBY
			                     && ping_count == 8'(SLEEP_EVERY - 1);
			metal_loss_detect <= warning;
		end
	end
endmodule
`default_nettype wire

/* File: wtip_tick_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Countdown request and expiry between the sequencer and its timer
interface wtip_tick_if;
	logic        load;
	logic [35:0] count;
	logic        expired;
	modport owner (output load, output count, input expired);
	modport timer (input load, input count, output expired);
endinterface
`default_nettype wire

/* File: wtip_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module wtip_timer (
	// Clock and reset
	input  wire logic clock,
	input  wire logic arst_n,
	// Request
	wtip_tick_if.timer tick
);
	logic [35:0] remain;
	logic        running;

	// Countdown; load restarts it, expiry pulses once when it reaches zero
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			remain  <= 36'h0;
			running <= 1'b0;
		end else if (tick.load) begin
			remain  <= tick.count;
			running <= 1'b1;
		end else if (running && remain != 36'h0) begin
			remain <= remain - 36'h1;
		end else begin
			running <= 1'b0;
		end
	end

	// Expiry reads registers only; a load term here would close a loop through
	// the sequencer, whose next state decides the load
	assign tick.expired = running && remain == 36'h0;
endmodule
`default_nettype wire
